//--- tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import wdc_pkg::*;
;
    localparam int          LIM [4] = '{0, 16, 32, 64};
    localparam logic [15:0] CT = WDC_CTRL_OFS;
    localparam logic [15:0] SV = WDC_SRV_OFS;
    localparam logic [15:0] ST = WDC_STAT_OFS;

    // clock, reset, slow clock divider
    logic         core_clk = 1'b0;
    logic         rst      = 1'b1;
    logic [2:0]   lpoDiv   = 3'h0;
    // register bus and outputs
    wdc_axi_req_t axiReq   = '{bready: 1'b1, rready: 1'b1, wstrb: 4'hf, default: '0};
    wdc_axi_rsp_t axiRsp;
    logic         sysResetReq;
    logic         irq;
    int           failures = 0;
    int           checked  = 0;
    int           resets   = 0;

    wdc_top #(.BUS_TMO_1(LIM[1]), .BUS_TMO_2(LIM[2]), .BUS_TMO_3(LIM[3])) i_dut (
        .core_clk(core_clk),
        .rst(rst),
        .axiReq(axiReq),
        .axiRsp(axiRsp),
        .low_power_osc_clock(lpoDiv[2]),
        .sysResetReq(sysResetReq),
        .irq(irq)
    );

    always #20 core_clk = ~core_clk;

    // slow clock of 8 core cycles, count of reset requests
    always @(posedge core_clk) begin
        lpoDiv <= lpoDiv + 3'h1;
        if (sysResetReq === 1'b1) resets <= resets + 1;
    end

    task automatic finish_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s: %h not %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic bound(input int k, input int lim);
        if (k >= lim) begin
            failures++;
            $display("BAD %0t wait ran out", $time);
            finish_test();
        end
    endtask : bound

    // one write (w high) or one read with expected data and response
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                       input logic [1:0] resp = WDC_RESP_OKAY);
        int k;
        axiReq.awvalid <= w;
        axiReq.wvalid  <= w;
        axiReq.arvalid <= !w;
        axiReq.awaddr  <= a;
        axiReq.araddr  <= a;
        axiReq.wdata   <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk);
            if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
            if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
            if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
            if (axiRsp.bvalid || axiRsp.rvalid) break;
        end
        bound(k, 20);
        if (!w) begin
            chk(axiRsp.rdata, d, "read data");
            chk(32'(axiRsp.rresp), 32'(resp), "read response");
        end else begin
            chk(32'(axiRsp.bresp), 32'(resp), "write response");
        end
    endtask : acc

    task automatic waitRst(input int lo, input int hi);
        int k;
        for (k = 0; k < hi; k++) begin
            @(posedge core_clk);
            if (sysResetReq === 1'b1) break;
        end
        chk(32'(k >= lo), 32'h1, "reset request too early");
        bound(k, hi);
    endtask : waitRst

    task automatic idle(input int c);
        repeat (c) @(posedge core_clk);
    endtask : idle

    task automatic hwRst();
        rst <= 1'b1;
        idle(2);
        rst <= 1'b0;
        idle(1);
    endtask : hwRst

    initial begin
        int s;
        hwRst();
        acc(1'b0, CT, 32'h0);
        acc(1'b0, SV, 32'h0);
        acc(1'b0, 16'h1200, 32'h0, WDC_RESP_SLVERR);
        acc(1'b1, 16'h1200, 32'h0, WDC_RESP_SLVERR);
        $display("test reset values done");
        for (s = 1; s < 4; s++) begin
            acc(1'b1, CT, 32'hfffffff2 | 32'(s << 2));
            acc(1'b1, CT, 32'h0);
            acc(1'b0, CT, 32'(s * 4 + 2));
            waitRst(LIM[s] - 11, LIM[s] - 3);
            acc(1'b0, CT, 32'h0);
            acc(1'b0, ST, 32'h4);
        end
        $display("test bus clock timeouts done");
        acc(1'b1, CT, 32'h4);
        waitRst(244, 268);
        acc(1'b0, ST, 32'h4);
        acc(1'b1, CT, 32'h5);
        acc(1'b1, SV, 32'h55);
        acc(1'b1, SV, 32'haa);
        acc(1'b0, ST, 32'h1);
        hwRst();
        acc(1'b1, CT, 32'h0);
        acc(1'b1, CT, 32'h6);
        idle(100);
        chk(32'(resets), 32'h4, "reset count");
        $display("test slow and disabled done");
        hwRst();
        acc(1'b1, WDC_MASK_OFS, 32'h2);
        acc(1'b0, WDC_MASK_OFS, 32'h2);
        acc(1'b1, CT, 32'h6);
        acc(1'b0, WDC_STATE_OFS, 32'h5);
        acc(1'b0, WDC_CNT_OFS, 32'h3);
        repeat (5) begin
            idle(3);
            acc(1'b1, SV, 32'h55);
            acc(1'b1, SV, 32'haa);
        end
        chk(32'(resets), 32'h4, "reset count");
        acc(1'b0, ST, 32'h1);
        acc(1'b1, SV, 32'h12);
        idle(1);
        chk(32'(resets), 32'h5, "reset count");
        chk(32'(irq), 32'h1, "interrupt");
        acc(1'b0, ST, 32'h2);
        chk(32'(irq), 32'h0, "interrupt");
        acc(1'b0, CT, 32'h0);
        acc(1'b1, SV, 32'haa);
        acc(1'b1, CT, 32'h7);
        acc(1'b1, SV, 32'h55);
        acc(1'b1, SV, 32'haa);
        idle(1);
        chk(32'(resets), 32'h7, "reset count");
        acc(1'b0, ST, 32'ha);
        acc(1'b1, CT, 32'h7);
        idle(8);
        acc(1'b1, SV, 32'h55);
        acc(1'b1, SV, 32'haa);
        acc(1'b0, ST, 32'h1);
        chk(32'(resets), 32'h7, "reset count");
        $display("test keys and window done");
        finish_test();
    end
endmodule : tb_top
`default_nettype wire

//--- wdc_pkg.sv
`default_nettype none
package wdc_pkg;

    // register byte offsets
    localparam logic [15:0] WDC_CTRL_OFS  = 16'h1100;
    localparam logic [15:0] WDC_SRV_OFS   = 16'h1104;
    localparam logic [15:0] WDC_STAT_OFS  = 16'h1108;
    localparam logic [15:0] WDC_MASK_OFS  = 16'h110c;
    localparam logic [15:0] WDC_CNT_OFS   = 16'h1110;
    localparam logic [15:0] WDC_STATE_OFS = 16'h1114;

    // control field positions
    localparam int WDC_WIN_BIT = 0;
    localparam int WDC_CLK_BIT = 1;
    localparam int WDC_TMO_LSB = 2;
    localparam int WDC_TMO_MSB = 3;

    // status and mask bit positions
    localparam int WDC_EV_SERVICE = 0;
    localparam int WDC_EV_BADKEY  = 1;
    localparam int WDC_EV_TIMEOUT = 2;
    localparam int WDC_EV_EARLY   = 3;
    localparam int WDC_EV_W       = 4;

    // reset values
    localparam logic [3:0]          WDC_CTRL_RST = 4'h0;
    localparam logic [WDC_EV_W-1:0] WDC_STAT_RST = 4'h0;
    localparam logic [WDC_EV_W-1:0] WDC_MASK_RST = 4'h0;

    // service keys
    localparam logic [7:0] WDC_KEY_FIRST  = 8'h55;
    localparam logic [7:0] WDC_KEY_SECOND = 8'haa;

    // timeout lengths in cycles of the selected clock
    localparam int unsigned WDC_LPO_TMO_1   = 32;
    localparam int unsigned WDC_LPO_TMO_2   = 256;
    localparam int unsigned WDC_LPO_TMO_3   = 1024;
    localparam int unsigned WDC_BUS_TMO_1_D = 8192;
    localparam int unsigned WDC_BUS_TMO_2_D = 65536;
    localparam int unsigned WDC_BUS_TMO_3_D = 262144;
    localparam int          WDC_CNT_W       = 19;

    // bus answers
    localparam logic [1:0] WDC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] WDC_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        WDC_TMO_OFF   = 2'b00,
        WDC_TMO_SHORT = 2'b01,
        WDC_TMO_MID   = 2'b10,
        WDC_TMO_LONG  = 2'b11
    } wdc_tmo_t;

    typedef enum logic [0:0] {
        WDC_KEY_IDLE  = 1'b0,
        WDC_KEY_ARMED = 1'b1
    } wdc_key_t;

    typedef struct packed {
        wdc_tmo_t tmo;
        logic     clkSel;
        logic     winEn;
    } wdc_cfg_t;

    typedef struct packed {
        logic        awvalid;
        logic [15:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [15:0] araddr;
        logic        rready;
    } wdc_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } wdc_axi_rsp_t;

    typedef struct packed {
        logic [2:0] shift;
        logic       tick;
    } wdc_sync_t;

    typedef struct packed {
        logic                 awHeld;
        logic [15:0]          awAddr;
        logic                 wHeld;
        logic [31:0]          wData;
        logic [3:0]           wStrb;
        logic                 bValid;
        logic [1:0]           bResp;
        logic                 rValid;
        logic [31:0]          rData;
        logic [1:0]           rResp;
        wdc_cfg_t             cfg;
        logic                 locked;
        wdc_key_t             key;
        logic [WDC_CNT_W-1:0] cnt;
        logic [WDC_EV_W-1:0]  status;
        logic [WDC_EV_W-1:0]  mask;
        logic                 sysRst;
    } wdc_state_t;

endpackage : wdc_pkg
`default_nettype wire

//--- wdc_tick_sync.sv
`timescale 1ns/10ps
`default_nettype none
module wdc_tick_sync
    import wdc_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // slow clock pin and its rising-edge strobe
    input  wire logic lpoPin,
    output logic      lpoTick
);

    wdc_sync_t q;
    wdc_sync_t d;

    // shift[0] feeds only shift[1]; edge taken between shift[1] and shift[2]
    always_comb begin
        d       = q;
        d.shift = {q.shift[1:0], lpoPin};
        d.tick  = q.shift[1] & ~q.shift[2];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign lpoTick = q.tick;

endmodule : wdc_tick_sync
`default_nettype wire

//--- wdc_top.sv
`timescale 1ns/10ps
`default_nettype none
module wdc_top
    import wdc_pkg::*;
#(
    parameter int unsigned BUS_TMO_1 = WDC_BUS_TMO_1_D,
    parameter int unsigned BUS_TMO_2 = WDC_BUS_TMO_2_D,
    parameter int unsigned BUS_TMO_3 = WDC_BUS_TMO_3_D
) (
    // clock and reset
    input  wire logic   core_clk,
    input  wire logic   rst,
    // register bus
    input  wire wdc_axi_req_t axiReq,
    output wdc_axi_rsp_t      axiRsp,
    // slow clock pin
    input  wire logic   low_power_osc_clock,
    // system outputs
    output logic        sysResetReq,
    output logic        irq
);

    wdc_state_t           q;
    wdc_state_t           d;
    logic                 lpoTick;
    logic                 cntTick;
    logic                 enabled;
    logic                 windowed;
    logic                 windowOpen;
    logic [WDC_CNT_W-1:0] limit;
    logic [WDC_CNT_W-1:0] threeQuarter;
    logic                 doWrite;
    logic                 keyWrite;
    logic                 statRead;
    logic                 serviced;
    logic [WDC_EV_W-1:0]  ev;
    logic                 resetReq;
    logic [31:0]          readData;
    logic [1:0]           readResp;

    wdc_tick_sync u_tick_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .lpoPin   (low_power_osc_clock),
        .lpoTick  (lpoTick)
    );

    // period select
    always_comb begin
        limit = '0;
        case (q.cfg.tmo)
            WDC_TMO_SHORT: begin
                limit = q.cfg.clkSel ? WDC_CNT_W'(BUS_TMO_1)
                                     : WDC_CNT_W'(WDC_LPO_TMO_1);
            end
            WDC_TMO_MID: begin
                limit = q.cfg.clkSel ? WDC_CNT_W'(BUS_TMO_2)
                                     : WDC_CNT_W'(WDC_LPO_TMO_2);
            end
            WDC_TMO_LONG: begin
                limit = q.cfg.clkSel ? WDC_CNT_W'(BUS_TMO_3)
                                     : WDC_CNT_W'(WDC_LPO_TMO_3);
            end
            default: begin
                limit = '0;
            end
        endcase
    end

    assign enabled      = (q.cfg.tmo != WDC_TMO_OFF);
    assign cntTick      = q.cfg.clkSel ? 1'b1 : lpoTick;
    assign windowed     = q.cfg.winEn & q.cfg.clkSel;
    assign threeQuarter = limit - (limit >> 2);
    assign windowOpen   = (q.cnt >= threeQuarter);
    assign doWrite      = q.awHeld & q.wHeld & ~q.bValid;

    // read mux
    always_comb begin
        readData = '0;
        readResp = WDC_RESP_OKAY;
        case (axiReq.araddr)
            WDC_CTRL_OFS: begin
                readData[3:0] = q.cfg;
            end
            WDC_SRV_OFS: begin
                readData = '0;
            end
            WDC_STAT_OFS: begin
                readData[WDC_EV_W-1:0] = q.status;
            end
            WDC_MASK_OFS: begin
                readData[WDC_EV_W-1:0] = q.mask;
            end
            WDC_CNT_OFS: begin
                readData[WDC_CNT_W-1:0] = q.cnt;
            end
            WDC_STATE_OFS: begin
                readData[3:0] = {windowOpen, enabled, q.key, q.locked};
            end
            default: begin
                readResp = WDC_RESP_SLVERR;
            end
        endcase
    end

    always_comb begin
        d        = q;
        d.sysRst = 1'b0;
        ev       = '0;
        keyWrite = 1'b0;
        serviced = 1'b0;
        statRead = 1'b0;

        // write address and data captured in either order
        if (axiReq.awvalid && !q.awHeld) begin
            d.awHeld = 1'b1;
            d.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && !q.wHeld) begin
            d.wHeld = 1'b1;
            d.wData = axiReq.wdata;
            d.wStrb = axiReq.wstrb;
        end
        if (q.bValid && axiReq.bready) begin
            d.bValid = 1'b0;
        end

        // register write
        if (doWrite) begin
            d.awHeld = 1'b0;
            d.wHeld  = 1'b0;
            d.bValid = 1'b1;
            d.bResp  = WDC_RESP_OKAY;
            case (q.awAddr)
                WDC_CTRL_OFS: begin
                    if (q.wStrb[0] && !q.locked) begin
                        d.cfg    = q.wData[3:0];
                        d.locked = 1'b1;
                    end
                end
                WDC_SRV_OFS: begin
                    keyWrite = q.wStrb[0];
                end
                WDC_MASK_OFS: begin
                    if (q.wStrb[0]) begin
                        d.mask = q.wData[WDC_EV_W-1:0];
                    end
                end
                WDC_STAT_OFS, WDC_CNT_OFS, WDC_STATE_OFS: begin
                    d.bResp = WDC_RESP_OKAY;
                end
                default: begin
                    d.bResp = WDC_RESP_SLVERR;
                end
            endcase
        end

        // key sequence
        if (keyWrite) begin
            case (q.key)
                WDC_KEY_IDLE: begin
                    if (q.wData[7:0] == WDC_KEY_FIRST) begin
                        d.key = WDC_KEY_ARMED;
                    end else begin
                        ev[WDC_EV_BADKEY] = 1'b1;
                    end
                end
                WDC_KEY_ARMED: begin
                    if (q.wData[7:0] == WDC_KEY_SECOND) begin
                        d.key = WDC_KEY_IDLE;
                        if (enabled && windowed && !windowOpen) begin
                            ev[WDC_EV_EARLY] = 1'b1;
                        end else begin
                            serviced = 1'b1;
                        end
                    end else if (q.wData[7:0] != WDC_KEY_FIRST) begin
                        d.key             = WDC_KEY_IDLE;
                        ev[WDC_EV_BADKEY] = 1'b1;
                    end
                end
                default: begin
                    d.key = WDC_KEY_IDLE;
                end
            endcase
        end

        // timeout counter
        if (serviced) begin
            d.cnt               = '0;
            ev[WDC_EV_SERVICE]  = 1'b1;
        end else if (!enabled) begin
            d.cnt = '0;
        end else if (cntTick) begin
            if (q.cnt == limit - WDC_CNT_W'(1)) begin
                ev[WDC_EV_TIMEOUT] = 1'b1;
            end else begin
                d.cnt = q.cnt + WDC_CNT_W'(1);
            end
        end

        // register read
        if (q.rValid && axiReq.rready) begin
            d.rValid = 1'b0;
        end
        if (axiReq.arvalid && !q.rValid) begin
            d.rValid = 1'b1;
            d.rData  = readData;
            d.rResp  = readResp;
            statRead = (axiReq.araddr == WDC_STAT_OFS);
        end

        // sticky events: read clears, a new event wins
        d.status = (statRead ? '0 : q.status) | ev;

        // any fault event asks for a system reset
        resetReq = ev[WDC_EV_BADKEY] | ev[WDC_EV_TIMEOUT] | ev[WDC_EV_EARLY];

        // system reset request
        if (resetReq) begin
            d.sysRst = 1'b1;
            d.cfg    = WDC_CTRL_RST;
            d.locked = 1'b0;
            d.cnt    = '0;
            d.key    = WDC_KEY_IDLE;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q        <= '0;
            q.bResp  <= WDC_RESP_OKAY;
            q.rResp  <= WDC_RESP_OKAY;
            q.cfg    <= WDC_CTRL_RST;
            q.key    <= WDC_KEY_IDLE;
            q.status <= WDC_STAT_RST;
            q.mask   <= WDC_MASK_RST;
        end else begin
            q <= d;
        end
    end

    // bus answers
    assign axiRsp.awready = ~q.awHeld;
    assign axiRsp.wready  = ~q.wHeld;
    assign axiRsp.bvalid  = q.bValid;
    assign axiRsp.bresp   = q.bResp;
    assign axiRsp.arready = ~q.rValid;
    assign axiRsp.rvalid  = q.rValid;
    assign axiRsp.rdata   = q.rData;
    assign axiRsp.rresp   = q.rResp;

    // system outputs
    assign sysResetReq = q.sysRst;
    assign irq         = |(q.status & q.mask);

endmodule : wdc_top
`default_nettype wire

//--- wdc_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
module wdc_top_checker
    import wdc_pkg::*;
#(
    parameter int unsigned BUS_TMO_1 = WDC_BUS_TMO_1_D,
    parameter int unsigned BUS_TMO_2 = WDC_BUS_TMO_2_D,
    parameter int unsigned BUS_TMO_3 = WDC_BUS_TMO_3_D
) (
    // clock and reset
    input wire logic         core_clk,
    input wire logic         rst,
    // register bus and reset request
    input wire wdc_axi_req_t axiReq,
    input wire wdc_axi_rsp_t axiRsp,
    input wire logic         sysResetReq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic rdTake;
    logic wrTake;
    logic srvTake;
    assign rdTake  = axiReq.arvalid && axiRsp.arready;
    assign wrTake  = axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
    assign srvTake = wrTake && axiReq.awaddr == WDC_SRV_OFS && axiReq.wstrb[0];

    a_ctrl_upper_zero: assert property (
        rdTake && axiReq.araddr == WDC_CTRL_OFS |=> axiRsp.rdata[31:4] == 28'h0)
        else $error("control upper bits set");
    a_bad_key_reset: assert property (
        srvTake && axiReq.wdata[7:0] != WDC_KEY_FIRST && axiReq.wdata[7:0] != WDC_KEY_SECOND
        |-> ##2 sysResetReq) else $error("bad key without reset");
    a_first_key_quiet: assert property (
        srvTake && axiReq.wdata[7:0] == WDC_KEY_FIRST |-> ##2 !sysResetReq)
        else $error("first key caused reset");
    a_reset_one_cycle: assert property (
        sysResetReq |=> !sysResetReq) else $error("reset request too long");
    a_unmapped_error: assert property (
        rdTake && axiReq.araddr == 16'h1200 |=> axiRsp.rresp == WDC_RESP_SLVERR)
        else $error("unmapped read accepted");
    a_service_reads_zero: assert property (
        rdTake && axiReq.araddr == WDC_SRV_OFS |=> axiRsp.rdata == 32'h0)
        else $error("service register readable");
    a_read_answer: assert property (
        rdTake |=> axiRsp.rvalid && !axiRsp.arready) else $error("read answer late");
    a_write_answer: assert property (
        wrTake |=> !axiRsp.awready ##1 axiRsp.bvalid) else $error("write answer late");
endmodule : wdc_top_checker

bind wdc_top wdc_top_checker #(
    .BUS_TMO_1(BUS_TMO_1),
    .BUS_TMO_2(BUS_TMO_2),
    .BUS_TMO_3(BUS_TMO_3)
) i_checker (
    .core_clk(core_clk),
    .rst(rst),
    .axiReq(axiReq),
    .axiRsp(axiRsp),
    .sysResetReq(sysResetReq)
);
`default_nettype wire
